// ---- spi_slave_pkg.sv ----
// shared constants and types for the spi slave serial port
package spi_slave_pkg;

  // register byte offsets on the axi4-lite bus
  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_BUFFER  = 8'h08;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h10;

  // status register fields
  localparam int STAT_SMP_BIT = 7;
  localparam int STAT_CKE_BIT = 6;
  localparam int STAT_BF_BIT  = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // control register fields
  localparam int CTL_WRITE_COLLISION_FLAG_BIT = 7;
  localparam int CTL_OV_BIT   = 6;
  localparam int CTL_EN_BIT   = 5;
  localparam int CTL_CKP_BIT  = 4;
  localparam int CTL_SEL_BIT  = 8;
  localparam logic [3:0] MODE_SLAVE_SS   = 4'h4;
  localparam logic [3:0] MODE_SLAVE_NOSS = 4'h5;

  // interrupt bits: 0 byte done, 1 collision, 2 overflow
  localparam int IRQ_W = 3;

  localparam int BYTE_W = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // pins after synchronisation
  typedef struct packed {
    logic sck;
    logic sdi;
    logic ss_a_n;
    logic ss_b_n;
  } spi_pins_t;

  // configuration handed to the shifter
  typedef struct packed {
    logic       enable;
    logic       use_ss;
    logic       sel_b;
    logic       clock_idle_polarity;
    logic       cke;
  } spi_cfg_t;

endpackage

// ---- spi_sync.sv ----
// two-flop synchroniser for the spi pins
`timescale 1ns/10ps
module spi_sync (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  // pins
  input  wire spi_slave_pkg::spi_pins_t pins_i,
  output      spi_slave_pkg::spi_pins_t pins_o
);
  import spi_slave_pkg::*;

  spi_pins_t meta_q;
  spi_pins_t sync_q;
  spi_pins_t meta_d;
  spi_pins_t sync_d;

  always_comb begin
    meta_d = pins_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '{sck: 1'b0, sdi: 1'b0, ss_a_n: 1'b1, ss_b_n: 1'b1};
      sync_q <= '{sck: 1'b0, sdi: 1'b0, ss_a_n: 1'b1, ss_b_n: 1'b1};
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign pins_o = sync_q;
endmodule

// ---- spi_shifter.sv ----
// bit shifter driven by the sampled external shift clock
`timescale 1ns/10ps
module spi_shifter (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  // pins and setup
  input  wire spi_slave_pkg::spi_pins_t pins_i,
  input  wire spi_slave_pkg::spi_cfg_t  cfg_i,
  input  wire logic                    halt_i,
  input  wire logic [7:0]              tx_byte_i,
  // results
  output      logic [7:0]              rx_byte_o,
  output      logic                    done_o,
  output      logic                    busy_o,
  output      logic                    sdo_o,
  output      logic                    sdo_oe_o
);
  import spi_slave_pkg::*;

  logic       sck_q, sck_d;
  logic [7:0] sr_q, sr_d;
  logic [2:0] cnt_q, cnt_d;
  logic       busy_q, busy_d;
  logic       done_q, done_d;
  logic       sdo_q, sdo_d;
  logic       sel_n, active, lead, trail, sck_rise, sck_fall;

  always_comb begin
    sel_n    = cfg_i.sel_b ? pins_i.ss_b_n : pins_i.ss_a_n;
    active   = cfg_i.enable && !halt_i && !(cfg_i.use_ss && sel_n);
    sck_rise = pins_i.sck && !sck_q;
    sck_fall = !pins_i.sck && sck_q;
    // output changes on the edge opposite the one where it is stable
    lead  = (cfg_i.cke ^ cfg_i.clock_idle_polarity) ? sck_fall : sck_rise;
    trail = (cfg_i.cke ^ cfg_i.clock_idle_polarity) ? sck_rise : sck_fall;
    sck_d  = pins_i.sck;
    sr_d   = sr_q;
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    sdo_d  = sdo_q;
    if (!active) begin
      cnt_d  = 3'h0;
      busy_d = 1'b0;
      sr_d   = tx_byte_i;
      sdo_d  = tx_byte_i[BYTE_W-1];
    end else if (trail) begin
      sr_d   = {sr_q[BYTE_W-2:0], pins_i.sdi};
      busy_d = 1'b1;
      cnt_d  = cnt_q + 3'h1;
      if (cnt_q == LAST_BIT) begin
        done_d = 1'b1;
        busy_d = 1'b0;
      end
    end else if (lead && busy_q) begin
      sdo_d = sr_q[BYTE_W-1];
    end else if (!busy_q && cnt_q == 3'h0) begin
      sr_d  = tx_byte_i;
      sdo_d = tx_byte_i[BYTE_W-1];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_q  <= 1'b0;
      sr_q   <= 8'h00;
      cnt_q  <= 3'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      sdo_q  <= 1'b0;
    end else begin
      sck_q  <= sck_d;
      sr_q   <= sr_d;
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
      sdo_q  <= sdo_d;
    end
  end

  assign rx_byte_o = sr_q;
  assign done_o    = done_q;
  assign busy_o    = busy_q || (cnt_q != 3'h0);
  assign sdo_o     = sdo_q;
  assign sdo_oe_o  = active;
endmodule

// ---- spi_slave_port.sv ----
// What this block does
// - shift only on external shift-clock pulses
// - shift data most significant bit first
// - after eight bits: buffer, full, irq
// - buffer write while shifting: drop, collision
// - reading buffer clears buffer-full flag
// - byte while full: overflow, stop link
// - every transfer sends and receives together
// - port idle until enable bit set
// - slave mode hands pins to port
// - optional low select from two pins
`timescale 1ns/10ps
module spi_slave_port (
  // clock and reset
  input  wire logic        CLK_SYS_I,
  input  wire logic        RSTN_I,
  // axi4-lite write
  input  wire logic [7:0]  AWADDR_I,
  input  wire logic        AWVALID_I,
  output      logic        AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output      logic        WREADY_O,
  output      logic [1:0]  BRESP_O,
  output      logic        BVALID_O,
  input  wire logic        BREADY_I,
  // axi4-lite read
  input  wire logic [7:0]  ARADDR_I,
  input  wire logic        ARVALID_I,
  output      logic        ARREADY_O,
  output      logic [31:0] RDATA_O,
  output      logic [1:0]  RRESP_O,
  output      logic        RVALID_O,
  input  wire logic        RREADY_I,
  // spi pins
  input  wire logic        SCK_I,
  input  wire logic        SDI_I,
  input  wire logic        SS_A_N_I,
  input  wire logic        SS_B_N_I,
  output      logic        SDO_O,
  output      logic        SDO_OE_O,
  // interrupt
  output      logic        IRQ_O
);
  import spi_slave_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // pins and shifter

  spi_pins_t  pins_raw, pins_s;
  spi_cfg_t   cfg;
  logic [7:0] rx_byte;
  logic       done, busy, sdo, sdo_oe;

  assign pins_raw = '{sck: SCK_I, sdi: SDI_I, ss_a_n: SS_A_N_I, ss_b_n: SS_B_N_I};

  spi_sync u_sync (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RSTN_I),
    .pins_i  (pins_raw),
    .pins_o  (pins_s)
  );

  ////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0]       stat_q, stat_d;
  logic [8:0]       ctl_q, ctl_d;
  logic [7:0]       buf_q, buf_d;
  logic [IRQ_W-1:0] ist_q, ist_d, msk_q, msk_d;
  logic             slave_mode;

  always_comb begin
    slave_mode = (ctl_q[3:0] == MODE_SLAVE_SS) || (ctl_q[3:0] == MODE_SLAVE_NOSS);
    cfg.enable = ctl_q[CTL_EN_BIT] && slave_mode;
    cfg.use_ss = (ctl_q[3:0] == MODE_SLAVE_SS);
    cfg.sel_b  = ctl_q[CTL_SEL_BIT];
    cfg.clock_idle_polarity    = ctl_q[CTL_CKP_BIT];
    cfg.cke    = stat_q[STAT_CKE_BIT];
  end

  spi_shifter u_shift (
    .clk_i     (CLK_SYS_I),
    .rst_n_i   (RSTN_I),
    .pins_i    (pins_s),
    .cfg_i     (cfg),
    .halt_i    (ctl_q[CTL_OV_BIT]),
    .tx_byte_i (buf_q),
    .rx_byte_o (rx_byte),
    .done_o    (done),
    .busy_o    (busy),
    .sdo_o     (sdo),
    .sdo_oe_o  (sdo_oe)
  );

  ////////////////////////////////////////////////////////////////////
  // axi4-lite slave

  logic        aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [7:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic        wr_go, rd_go, wr_lo;
  logic        out_q, out_d, oe_q, oe_d, irq_q, irq_d;
  logic        awr_q, awr_d, wrd_q, wrd_d, arr_q, arr_d;

  always_comb begin
    aw_d  = aw_q;
    w_d   = w_q;
    awa_d = awa_q;
    wd_d  = wd_q;
    b_d   = b_q && !BREADY_I;
    br_d  = br_q;
    r_d   = r_q && !RREADY_I;
    rr_d  = rr_q;
    rd_d  = rd_q;
    if (AWVALID_I && !aw_q && !b_q) begin
      aw_d  = 1'b1;
      awa_d = AWADDR_I;
    end
    if (WVALID_I && !w_q && !b_q) begin
      w_d  = 1'b1;
      wd_d = WDATA_I;
    end
    wr_go = aw_q && w_q && !b_q;
    wr_lo = wr_go && WSTRB_I[0];
    if (wr_go) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      b_d  = 1'b1;
      br_d = (awa_q <= OFS_IRQ_MSK && awa_q[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    end
    rd_go = ARVALID_I && !r_q;
    if (rd_go) begin
      r_d  = 1'b1;
      rr_d = RESP_OKAY;
      case (ARADDR_I)
        OFS_STATUS:  rd_d = {24'h0, stat_q};
        OFS_CONTROL: rd_d = {23'h0, ctl_q};
        OFS_BUFFER:  rd_d = {24'h0, buf_q};
        OFS_IRQ_ST:  rd_d = {29'h0, ist_q};
        OFS_IRQ_MSK: rd_d = {29'h0, msk_q};
        default: begin
          rd_d = 32'h0;
          rr_d = RESP_SLVERR;
        end
      endcase
    end
    // readies come from next state so the pins stand straight off flops
    awr_d = !aw_d && !b_d;
    wrd_d = !w_d && !b_d;
    arr_d = !r_d;
  end

  ////////////////////////////////////////////////////////////////////
  // register behaviour

  always_comb begin
    stat_d = stat_q;
    ctl_d  = ctl_q;
    buf_d  = buf_q;
    ist_d  = ist_q;
    msk_d  = msk_q;
    if (wr_lo) begin
      case (awa_q)
        OFS_STATUS: begin
          stat_d[STAT_SMP_BIT] = wd_q[STAT_SMP_BIT];
          stat_d[STAT_CKE_BIT] = wd_q[STAT_CKE_BIT];
        end
        OFS_CONTROL: ctl_d = {wd_q[8], wd_q[7:0]};
        OFS_BUFFER: begin
          if (busy || done) ctl_d[CTL_WRITE_COLLISION_FLAG_BIT] = 1'b1;
          else buf_d = wd_q[7:0];
        end
        OFS_IRQ_ST:  ist_d = ist_q & ~wd_q[IRQ_W-1:0];
        OFS_IRQ_MSK: msk_d = wd_q[IRQ_W-1:0];
        default: ;
      endcase
    end
    if (rd_go && ARADDR_I == OFS_BUFFER) stat_d[STAT_BF_BIT] = 1'b0;
    if (wr_lo && awa_q == OFS_BUFFER && (busy || done)) ist_d[1] = 1'b1;
    if (done) begin
      if (stat_q[STAT_BF_BIT]) begin
        ctl_d[CTL_OV_BIT] = 1'b1;
        ist_d[2] = 1'b1;
      end else begin
        buf_d = rx_byte;
        stat_d[STAT_BF_BIT] = 1'b1;
      end
      ist_d[0] = 1'b1;
    end
    out_d = sdo;
    oe_d  = sdo_oe;
    irq_d = |(ist_d & msk_d);
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      stat_q <= STATUS_RESET;
      ctl_q  <= 9'h000;
      buf_q  <= 8'h00;
      ist_q  <= 3'h0;
      msk_q  <= 3'h0;
      aw_q   <= 1'b0;
      w_q    <= 1'b0;
      b_q    <= 1'b0;
      r_q    <= 1'b0;
      awa_q  <= 8'h00;
      wd_q   <= 32'h0;
      rd_q   <= 32'h0;
      br_q   <= 2'h0;
      rr_q   <= 2'h0;
      out_q  <= 1'b0;
      oe_q   <= 1'b0;
      irq_q  <= 1'b0;
      awr_q  <= 1'b1;
      wrd_q  <= 1'b1;
      arr_q  <= 1'b1;
    end else begin
      stat_q <= stat_d;
      ctl_q  <= ctl_d;
      buf_q  <= buf_d;
      ist_q  <= ist_d;
      msk_q  <= msk_d;
      aw_q   <= aw_d;
      w_q    <= w_d;
      b_q    <= b_d;
      r_q    <= r_d;
      awa_q  <= awa_d;
      wd_q   <= wd_d;
      rd_q   <= rd_d;
      br_q   <= br_d;
      rr_q   <= rr_d;
      out_q  <= out_d;
      oe_q   <= oe_d;
      irq_q  <= irq_d;
      awr_q  <= awr_d;
      wrd_q  <= wrd_d;
      arr_q  <= arr_d;
    end
  end

  assign AWREADY_O = awr_q;
  assign WREADY_O  = wrd_q;
  assign BVALID_O  = b_q;
  assign BRESP_O   = br_q;
  assign ARREADY_O = arr_q;
  assign RVALID_O  = r_q;
  assign RDATA_O   = rd_q;
  assign RRESP_O   = rr_q;
  assign SDO_O     = out_q;
  assign SDO_OE_O  = oe_q;
  assign IRQ_O     = irq_q;

  ////////////////////////////////////////////////////////////////////
  // checks

  chk_done_sets_full: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    done && !stat_q[STAT_BF_BIT] |=> stat_q[STAT_BF_BIT] && buf_q == $past(rx_byte))
    else $error("byte done did not fill buffer");
  chk_overflow_set: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    done && stat_q[STAT_BF_BIT] |=> ctl_q[CTL_OV_BIT] && $stable(buf_q))
    else $error("overflow not flagged");
  chk_overflow_halts: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    ctl_q[CTL_OV_BIT] |=> !done && !SDO_OE_O)
    else $error("link active during overflow");
  chk_collision_drop: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    wr_lo && awa_q == OFS_BUFFER && busy && !done |=> ctl_q[CTL_WRITE_COLLISION_FLAG_BIT] && $stable(buf_q))
    else $error("collision write not dropped");
  chk_read_clears: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    rd_go && ARADDR_I == OFS_BUFFER && !done |=> !stat_q[STAT_BF_BIT])
    else $error("buffer read left full flag");
  chk_disabled_idle: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    !ctl_q[CTL_EN_BIT] [*3] |-> !SDO_OE_O && !done)
    else $error("port active while disabled");
  chk_deselect_off: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    cfg.use_ss && (cfg.sel_b ? pins_s.ss_b_n : pins_s.ss_a_n) |=> !SDO_OE_O)
    else $error("output driven while deselected");
  chk_irq_level: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    done && msk_q[0] |=> IRQ_O)
    else $error("irq missing after byte");
  chk_collision_irq: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    wr_lo && awa_q == OFS_BUFFER && (busy || done) |=> ist_q[1])
    else $error("collision not raised in irq status");
  chk_full_from_done: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    $rose(stat_q[STAT_BF_BIT]) |-> $past(done))
    else $error("buffer full set without a byte");
  chk_full_not_writable: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    wr_lo && awa_q == OFS_STATUS && !done && !(rd_go && ARADDR_I == OFS_BUFFER)
    |=> $stable(stat_q[STAT_BF_BIT]))
    else $error("buffer full changed by status write");
  chk_enable_gate: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    !cfg.enable |=> !done && !SDO_OE_O)
    else $error("port active while not enabled in slave mode");
endmodule

// ---- spi_master_model.sv ----
// behavioural spi master that drives clock, select and data
`timescale 1ns/10ps
module spi_master_model (
  // pins toward the slave
  output logic      sck_o,
  output logic      sdi_o,
  output logic      ss_a_n_o,
  output logic      ss_b_n_o,
  input  wire logic sdo_i
);
  initial begin
    sck_o = 1'b0;
    sdi_o = 1'b0;
    ss_a_n_o = 1'b1;
    ss_b_n_o = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  // one byte each way; p is the idle level, h samples on the second edge
  task automatic xfer(input logic b, input logic p, input logic h, input logic [7:0] t,
                      output logic [7:0] r);
    // idle level moves only while deselected, so no stray edge reaches the shifter
    if (sck_o !== p) begin
      sck_o = p;
      #160;
    end
    if (b) ss_b_n_o = 1'b0;
    else ss_a_n_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (!h) sdi_o = t[i];
      #160 sck_o = ~p;
      if (h) sdi_o = t[i];
      else r[i] = sdo_i;
      #160 sck_o = p;
      if (h) r[i] = sdo_i;
    end
    #160;
    // released data line must not look held
    sdi_o = ~t[0];
    ss_a_n_o = 1'b1;
    ss_b_n_o = 1'b1;
  endtask
endmodule

// ---- spi_slave_port_tb_top.sv ----
// self-checking bench for the spi slave serial port
`timescale 1ns/10ps
module spi_slave_port_tb_top;
  import spi_slave_pkg::*;
  logic        clk;
  logic        rst_n;
  logic [7:0]  awaddr;
  logic [7:0]  araddr;
  logic        awvalid;
  logic        wvalid;
  logic        bready;
  logic        arvalid;
  logic        rready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  wire logic   awready, wready, bvalid, arready, rvalid, irq;
  wire logic   sck, sdi, ss_a_n, ss_b_n, sdo, sdo_oe;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  int          fail_count;
  int          num_checks;
  logic [31:0] seed;
  logic [31:0] rd;
  logic [7:0]  tx;
  logic [7:0]  got;
  logic [1:0]  resp;
  logic        idle_hi;
  logic        late_smp;

  spi_slave_port u_spi_slave_port (
    .CLK_SYS_I(clk), .RSTN_I(rst_n),
    .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
    .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wready),
    .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
    .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
    .SCK_I(sck), .SDI_I(sdi), .SS_A_N_I(ss_a_n), .SS_B_N_I(ss_b_n),
    .SDO_O(sdo), .SDO_OE_O(sdo_oe), .IRQ_O(irq)
  );
  spi_master_model u_spi_master_model (
    .sck_o(sck), .sdi_o(sdi), .ss_a_n_o(ss_a_n), .ss_b_n_o(ss_b_n), .sdo_i(sdo)
  );

  always #20 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // ready values are taken before the edge, so no race with the flops
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ra, rw, dn;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    dn = 1'b0;
    while (!dn) begin
      @(negedge clk);
      ra = awready;
      rw = wready;
      dn = bvalid;
      resp = bresp;
      @(posedge clk);
      if (ra) awvalid <= 1'b0;
      if (rw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    logic ok, dn;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    dn = 1'b0;
    while (!dn) begin
      @(negedge clk);
      ok = arready;
      dn = rvalid;
      rd = rdata;
      resp = rresp;
      @(posedge clk);
      if (ok) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  // full wait when no interrupt is expected, so a late one is caught
  task automatic spi(input logic b, input logic [7:0] t, input logic e);
    int n;
    @(posedge clk);
    #7;
    u_spi_master_model.xfer(b, idle_hi, late_smp, t, got);
    n = 0;
    while (n < 40 && !(e && irq)) begin
      @(posedge clk);
      n++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    wdata = '0;
    wstrb = 4'hf;
    seed = 32'h5a06a18d;
    idle_hi = 1'b0;
    late_smp = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rdr(OFS_STATUS);
    chk(rd, {24'h0, STATUS_RESET});
    rdr(8'h14);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    chk(rd, 32'h0);
    wr(8'h14, 32'h0);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(OFS_IRQ_MSK, 32'h7);
    chk({30'h0, resp}, {30'h0, RESP_OKAY});
    spi(1'b0, 8'ha5, 1'b0);
    chk({31'h0, irq}, 32'h0);
    $display("test disabled done");
    wr(OFS_STATUS, 32'h40);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      tx = (i == 0) ? 8'h01 : (i == 1) ? 8'hfe : seed[7:0];
      wr(OFS_CONTROL, {28'h2, i[0] ? MODE_SLAVE_NOSS : MODE_SLAVE_SS});
      wr(OFS_BUFFER, {24'h0, tx});
      spi(1'b0, seed[15:8], 1'b1);
      chk({24'h0, got}, {24'h0, tx});
      chk({31'h0, irq}, 32'h1);
      if (i[0]) chk({31'h0, sdo_oe}, 32'h1);
      rdr(OFS_STATUS);
      chk(rd, 32'h41);
      rdr(OFS_BUFFER);
      chk(rd, {24'h0, seed[15:8]});
      rdr(OFS_STATUS);
      chk(rd, 32'h40);
      wr(OFS_IRQ_ST, 32'h1);
      spi(1'b0, 8'h00, 1'b0);
      chk({24'h0, got}, {24'h0, seed[15:8]});
      rdr(OFS_BUFFER);
      chk(rd, 32'h0);
      wr(OFS_IRQ_ST, 32'h1);
    end
    $display("test random done");
    wr(OFS_CONTROL, 32'h24);
    wr(OFS_IRQ_ST, 32'h7);
    wr(OFS_BUFFER, 32'h3c);
    fork
      spi(1'b0, 8'h99, 1'b1);
      begin
        repeat (60) @(posedge clk);
        wr(OFS_BUFFER, 32'hc3);
      end
    join
    chk({24'h0, got}, 32'h3c);
    rdr(OFS_CONTROL);
    chk(rd, 32'ha4);
    rdr(OFS_IRQ_ST);
    chk(rd, 32'h3);
    rdr(OFS_BUFFER);
    wr(OFS_CONTROL, 32'h24);
    rdr(OFS_CONTROL);
    chk(rd, 32'h24);
    wr(OFS_IRQ_ST, 32'h7);
    $display("test collision done");
    wr(OFS_IRQ_MSK, 32'h0);
    spi(1'b0, 8'h5a, 1'b0);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_IRQ_MSK, 32'h7);
    spi(1'b0, 8'h6b, 1'b1);
    rdr(OFS_CONTROL);
    chk(rd, 32'h64);
    chk({31'h0, sdo_oe}, 32'h0);
    rdr(OFS_BUFFER);
    chk(rd, 32'h5a);
    wr(OFS_CONTROL, 32'h24);
    wr(OFS_IRQ_ST, 32'h7);
    $display("test overflow done");
    wr(OFS_CONTROL, 32'h124);
    wr(OFS_BUFFER, 32'h96);
    spi(1'b0, 8'h11, 1'b0);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, sdo_oe}, 32'h0);
    spi(1'b1, 8'h22, 1'b1);
    chk({24'h0, got}, 32'h96);
    rdr(OFS_BUFFER);
    chk(rd, 32'h22);
    $display("test select done");
    wr(OFS_IRQ_ST, 32'h7);
    // idle-high first-edge, idle-high second-edge, idle-low second-edge
    for (int k = 0; k < 3; k++) begin
      idle_hi = (k < 2);
      late_smp = (k > 0);
      seed = lfsr(seed);
      wr(OFS_STATUS, {25'h0, !late_smp, 6'h0});
      wr(OFS_CONTROL, {26'h0, 1'b1, idle_hi, MODE_SLAVE_SS});
      wr(OFS_BUFFER, {24'h0, seed[7:0]});
      spi(1'b0, seed[15:8], 1'b1);
      chk({24'h0, got}, {24'h0, seed[7:0]});
      chk({31'h0, irq}, 32'h1);
      rdr(OFS_BUFFER);
      chk(rd, {24'h0, seed[15:8]});
      wr(OFS_IRQ_ST, 32'h1);
    end
    $display("test polarity done");
    final_report;
  end
  initial begin
    #3000000;
    fail_count++;
    final_report;
  end
endmodule
